//--- rtl/radio_aux_regs.sv
// Auxiliary control and identification registers of the radio, device end.
// Assumes the host issues one byte access per cycle on the shared pclk.
//
// Notes on behaviour
// RULE1 - Power-saving bit seven gates unused circuitry off
// RULE2 - Power-saving writes need analog write-enable bit
// RULE3 - Host sets power-saving bit during initialisation
// RULE4 - Carrier bit seven overrides carrier detection
// RULE5 - Carrier writes need analog write-enable bit
// RULE6 - Host writes zero to reserved bits
// RULE7 - Host loads 0x41 into both clock registers
// RULE8 - Lock wait equals count times two microseconds
// RULE9 - Timed wait only under automatic synthesiser control
// RULE10 - Lock count resets to 0x64
// RULE11 - Identifier bits 31 and 30 read zero
// RULE12 - Identifier readable only with read-enable set
// RULE13 - Host clears read-enable after identifier reads
// RULE14 - Identifier register ignores writes
// RULE15 - Identifier is per-chip thirty bits
// RULE16 - Lowest identifier address holds least significant byte
// RULE17 - Gated write while disabled leaves value unchanged
`timescale 1ns/1ps
module radio_aux_regs #(
  parameter logic [29:0] mfg_id = 30'h0a5a5a5  // Arbitrary value
) (
  input  wire logic pclk,
  input  wire logic presetn,
  radio_aux_if.device bus,
  input  wire logic synth_start,
  output logic      synth_locked,
  output logic      power_save,
  output logic      carrier_override,
  output logic [7:0] clock_override,
  output logic [7:0] clock_enable
);
  // ----------------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------------
  localparam int step_cycles = radio_aux_pkg::lock_step_cycles;
  // The step counter is 16 bits wide; a longer step would be truncated and end the wait early
  if (step_cycles < 1 || step_cycles > 65536) begin : g_step_fits
    $error("lock step count does not fit the step counter");
  end

  logic [7:0]  analog_ctrl;
  logic [7:0]  control;
  logic [7:0]  power_saving;
  logic [7:0]  carrier_reg;
  logic [7:0]  clock_override_reg;
  logic [7:0]  clock_enable_reg;
  logic [7:0]  lock_delay_reg;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [7:0]  steps_left;
  logic [15:0] step_cnt;
  logic        waiting;

  // ----------------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------------
  wire wr           = bus.req & bus.write;
  wire write_open   = analog_ctrl[radio_aux_pkg::write_enable_bit];
  wire id_open      = analog_ctrl[radio_aux_pkg::id_read_enable_bit];
  wire hit_analog   = bus.addr == radio_aux_pkg::analog_ctrl_addr;
  wire hit_control  = bus.addr == radio_aux_pkg::control_addr;
  wire hit_power    = bus.addr == radio_aux_pkg::power_saving_addr;
  wire hit_carrier  = bus.addr == radio_aux_pkg::carrier_override_addr;
  wire hit_clk_ovr  = bus.addr == radio_aux_pkg::clock_override_addr;
  wire hit_clk_en   = bus.addr == radio_aux_pkg::clock_enable_addr;
  wire hit_lock     = bus.addr == radio_aux_pkg::lock_delay_addr;
  wire hit_id       = bus.addr[6:2] == radio_aux_pkg::mfg_id_addr[6:2];
  // RULE11 RULE15 upper bits zero
  wire [31:0] id_word = {2'b00, mfg_id};
  // RULE16 byte lane select
  wire [7:0]  id_byte = id_word[bus.addr[1:0]*8 +: 8];
  wire [15:0] step_last = 16'(step_cycles - 1);
  wire        auto_synth = ~control[radio_aux_pkg::auto_synth_off_bit];
  wire        rd         = bus.req & ~bus.write;

  // ----------------------------------------------------------------------------
  // Write strobes
  // ----------------------------------------------------------------------------
  wire wr_analog    = wr & hit_analog;
  wire wr_control   = wr & hit_control;
  // RULE2 RULE17 gated write
  wire wr_power     = wr & hit_power & write_open;
  // RULE5 RULE17 gated write
  wire wr_carrier   = wr & hit_carrier & write_open;
  wire wr_clk_ovr   = wr & hit_clk_ovr;
  wire wr_clk_en    = wr & hit_clk_en;
  wire wr_lock      = wr & hit_lock;
  // RULE14 identifier has no write strobe

  // ----------------------------------------------------------------------------
  // Read select
  // ----------------------------------------------------------------------------
  // RULE12 gated identifier read
  wire [7:0] id_read    = id_open ? id_byte : 8'h00;
  // Unmapped addresses read as zero so a stray read sees no stale byte
  wire [7:0] read_byte  = hit_analog  ? analog_ctrl        :
                          hit_control ? control            :
                          hit_power   ? power_saving       :
                          hit_carrier ? carrier_reg        :
                          hit_clk_ovr ? clock_override_reg :
                          hit_clk_en  ? clock_enable_reg   :
                          hit_lock    ? lock_delay_reg     :
                          hit_id      ? id_read            : 8'h00;

  // ----------------------------------------------------------------------------
  // Lock timer decode
  // ----------------------------------------------------------------------------
  // RULE9 auto synth only
  wire        start_timed = synth_start & auto_synth;
  wire        no_delay    = lock_delay_reg == 8'h00;
  wire        step_done   = step_cnt == step_last;
  wire        final_step  = steps_left == 8'h01;

  // ----------------------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------------------
  // Analog and control bytes only supply gating bits to the other registers and the lock timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog_ctrl <= 8'h00;
      control     <= 8'h00;
    end else begin
      if (wr_analog) analog_ctrl <= bus.wdata;
      if (wr_control) control <= bus.wdata;
    end
  end

  // A closed gate drops the byte silently; the host sees no refusal
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_saving <= radio_aux_pkg::power_saving_reset;
      carrier_reg  <= radio_aux_pkg::carrier_reset;
    end else begin
      if (wr_power) power_saving <= bus.wdata;
      if (wr_carrier) carrier_reg <= bus.wdata;
    end
  end

  // Clock bytes reset to zero; the host must load them before use
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_override_reg <= radio_aux_pkg::clock_reset;
      clock_enable_reg   <= radio_aux_pkg::clock_reset;
      // RULE10 lock count reset
      lock_delay_reg     <= radio_aux_pkg::lock_delay_reset;
    end else begin
      if (wr_clk_ovr) clock_override_reg <= bus.wdata;
      if (wr_clk_en) clock_enable_reg <= bus.wdata;
      if (wr_lock) lock_delay_reg <= bus.wdata;
    end
  end

  // ----------------------------------------------------------------------------
  // Read path: answer one cycle after the request
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata  <= 8'h00;
      rvalid <= 1'b0;
    end else begin
      rvalid <= rd;
      // Holding the byte between reads lets the host sample it late
      if (rd) rdata <= read_byte;
    end
  end
  assign bus.rdata  = rdata;
  assign bus.rvalid = rvalid;

  // ----------------------------------------------------------------------------
  // Synthesiser lock timer
  // ----------------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      waiting      <= 1'b0;
      steps_left   <= 8'h00;
      step_cnt     <= 16'h0000;
      synth_locked <= 1'b0;
    // A new start restarts the wait even while one is running
    end else if (start_timed) begin
      waiting      <= ~no_delay;
      steps_left   <= lock_delay_reg;
      step_cnt     <= 16'h0000;
      synth_locked <= no_delay;
    end else if (waiting) begin
      // RULE8 count two-microsecond steps
      if (step_done) begin
        step_cnt <= 16'h0000;
        if (final_step) begin
          waiting      <= 1'b0;
          synth_locked <= 1'b1;
        end
        steps_left <= steps_left - 8'h01;
      end else begin
        step_cnt <= step_cnt + 16'h0001;
      end
    end
  end

  // RULE1 power saving output
  assign power_save       = power_saving[radio_aux_pkg::active_bit];
  // RULE4 carrier override output
  assign carrier_override = carrier_reg[radio_aux_pkg::active_bit];
  assign clock_override   = clock_override_reg;
  assign clock_enable     = clock_enable_reg;
endmodule : radio_aux_regs

//--- inc/radio_aux_pkg.sv
// Constants shared by the radio auxiliary register bank and its host controller.
// Assumes 8-bit byte-wide register access with 7-bit addresses, as on the radio's serial port.
package radio_aux_pkg;
  // ----------------------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------------------
  localparam logic [6:0] analog_ctrl_addr     = 7'h20;
  localparam logic [6:0] control_addr         = 7'h03;
  localparam logic [6:0] power_saving_addr    = 7'h2e;
  localparam logic [6:0] carrier_override_addr = 7'h2f;
  localparam logic [6:0] clock_override_addr  = 7'h32;
  localparam logic [6:0] clock_enable_addr    = 7'h33;
  localparam logic [6:0] lock_delay_addr      = 7'h38;
  localparam logic [6:0] mfg_id_addr          = 7'h3c;
  // ----------------------------------------------------------------------------
  // Field positions and values
  // ----------------------------------------------------------------------------
  localparam int         active_bit           = 7;
  localparam int         write_enable_bit     = 6;
  localparam int         id_read_enable_bit   = 5;
  localparam int         auto_synth_off_bit   = 1;
  localparam logic [7:0] power_saving_reset   = 8'h00;
  localparam logic [7:0] carrier_reset        = 8'h00;
  localparam logic [7:0] clock_reset          = 8'h00;
  localparam logic [7:0] lock_delay_reset     = 8'h64;
  localparam logic [7:0] clock_init_value     = 8'h41;
  localparam logic [7:0] active_bit_value     = 8'h80;
  localparam logic [7:0] write_enable_value   = 8'h40;
  localparam logic [7:0] id_read_enable_value = 8'h20;
  // ----------------------------------------------------------------------------
  // Timing: lock delay step
  // ----------------------------------------------------------------------------
  localparam int         clock_mhz            = 200;
  localparam int         lock_step_ns         = 2000;
  localparam int         lock_step_cycles     = lock_step_ns * clock_mhz / 1000;
  // ----------------------------------------------------------------------------
  // Host controller APB registers (word offsets)
  // ----------------------------------------------------------------------------
  localparam logic [7:0] host_cmd_offset      = 8'h00;
  localparam logic [7:0] host_status_offset   = 8'h04;
  localparam logic [7:0] host_rdata_offset    = 8'h08;
  localparam logic [7:0] host_mfg_id_offset   = 8'h0c;
  localparam int         cmd_go_bit           = 16;
  localparam int         cmd_write_bit        = 15;
  localparam int         cmd_init_bit         = 17;
  localparam int         cmd_id_bit           = 18;
endpackage : radio_aux_pkg

//--- inc/radio_aux_if.sv
// Byte-wide register port between the host controller and the radio register bank.
// Assumes both ends run on the same pclk; one access per cycle, reads answer next cycle.
`timescale 1ns/1ps
interface radio_aux_if;
  logic       req;
  logic       write;
  logic [6:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic       rvalid;
  modport device (input req, input write, input addr, input wdata, output rdata, output rvalid);
  modport host   (output req, output write, output addr, output wdata, input rdata, input rvalid);
endinterface : radio_aux_if

//--- rtl/radio_aux_host.sv
// Host controller driving the radio auxiliary registers, commanded over APB.
// Assumes the radio bank answers reads one cycle after the request.
`timescale 1ns/1ps
module radio_aux_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  radio_aux_if.host        radio
);
  typedef enum {idle_s, step_s, wait_s} state_t;

  state_t      state;
  logic [3:0]  step;
  logic [3:0]  last_step;
  logic        seq_kind;
  logic        busy;
  logic [7:0]  rbyte;
  logic [31:0] id_word;
  logic        req;
  logic        wr;
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic [14:0] single;

  // ----------------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------------
  wire access   = psel & penable;
  wire hit_cmd  = paddr == radio_aux_pkg::host_cmd_offset;
  wire hit_stat = paddr == radio_aux_pkg::host_status_offset;
  wire hit_rd   = paddr == radio_aux_pkg::host_rdata_offset;
  wire hit_id   = paddr == radio_aux_pkg::host_mfg_id_offset;
  wire go       = access & pwrite & hit_cmd & ~busy;
  // Read steps one to four land in identifier bytes zero to three
  wire [1:0] id_lane = 2'(step - 4'h1);
  assign pready  = 1'b1;
  assign pslverr = access & ~(hit_cmd | hit_stat | hit_rd | hit_id);
  assign prdata  = hit_stat ? {31'h0, busy} : hit_rd ? {24'h0, rbyte} :
                   hit_id ? id_word : {17'h0, single};

  // ----------------------------------------------------------------------------
  // Sequences: 0 = initialisation (steps 0 to 4) or single (step 5), 1 = identifier fetch
  // ----------------------------------------------------------------------------
  always_comb begin
    req   = 1'b1;
    wr    = 1'b1;
    addr  = radio_aux_pkg::analog_ctrl_addr;
    wdata = 8'h00;
    if (!seq_kind) begin
      case (step)
        // RULE2 RULE5 open writes first
        4'h0: wdata = radio_aux_pkg::write_enable_value;
        // RULE3 RULE6 set active bit only
        4'h1: begin
          addr  = radio_aux_pkg::power_saving_addr;
          wdata = radio_aux_pkg::active_bit_value;
        end
        // RULE7 clock registers
        4'h2: begin
          addr  = radio_aux_pkg::clock_override_addr;
          wdata = radio_aux_pkg::clock_init_value;
        end
        4'h3: begin
          addr  = radio_aux_pkg::clock_enable_addr;
          wdata = radio_aux_pkg::clock_init_value;
        end
        4'h4: wdata = 8'h00;
        4'h5: begin
          addr  = single[13:7];
          wdata = single[7:0];
          wr    = single[14];
        end
        default: req = 1'b0;
      endcase
    end else begin
      case (step)
        4'h0: wdata = radio_aux_pkg::id_read_enable_value;
        4'h1, 4'h2, 4'h3, 4'h4: begin
          wr   = 1'b0;
          addr = radio_aux_pkg::mfg_id_addr | 7'(step - 4'h1);
        end
        // RULE13 drop read enable
        4'h5: wdata = 8'h00;
        default: req = 1'b0;
      endcase
    end
    if (state != step_s) req = 1'b0;
  end

  assign radio.req   = req;
  assign radio.write = wr;
  assign radio.addr  = addr;
  assign radio.wdata = wdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= idle_s;
      step      <= 4'h0;
      last_step <= 4'h0;
      seq_kind  <= 1'b0;
      busy      <= 1'b0;
      rbyte     <= 8'h00;
      id_word   <= 32'h0;
      single    <= 15'h0;
    end else begin
      case (state)
        idle_s: if (go) begin
          busy   <= 1'b1;
          single <= {pwdata[radio_aux_pkg::cmd_write_bit], pwdata[13:0]};
          state  <= step_s;
          if (pwdata[radio_aux_pkg::cmd_id_bit]) begin
            seq_kind  <= 1'b1;
            step      <= 4'h0;
            last_step <= 4'h5;
          end else if (pwdata[radio_aux_pkg::cmd_init_bit]) begin
            seq_kind  <= 1'b0;
            step      <= 4'h0;
            last_step <= 4'h4;
          end else begin
            seq_kind  <= 1'b0;
            step      <= 4'h5;
            last_step <= 4'h5;
          end
        end
        step_s: state <= (wr) ? ((step == last_step) ? idle_s : step_s) : wait_s;
        wait_s: if (radio.rvalid) begin
          if (seq_kind) id_word[8*id_lane +: 8] <= radio.rdata;
          else rbyte <= radio.rdata;
          state <= (step == last_step) ? idle_s : step_s;
        end
        default: state <= idle_s;
      endcase
      if ((state == step_s && wr) || (state == wait_s && radio.rvalid)) begin
        if (step == last_step) busy <= 1'b0;
        else step <= step + 4'h1;
      end
    end
  end
endmodule : radio_aux_host

//--- tb/radio_aux_assertions.sv
// Concurrent checks on the byte link between host controller and register bank.
// Assumes one pclk domain; the bench hands in the link signals and bank outputs.
`timescale 1ns/1ps
module radio_aux_assertions (
  input wire logic       pclk,
  input wire logic       presetn,
  input wire logic       req,
  input wire logic       write,
  input wire logic [6:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic       rvalid,
  input wire logic       synth_start,
  input wire logic       synth_locked,
  input wire logic       power_save,
  input wire logic       carrier_override
);
  // ----------------------------------------------------------------------------
  // Shadows of the gating registers, rebuilt from link writes
  // ----------------------------------------------------------------------------
  logic [7:0] analog;
  logic [7:0] control;
  logic [7:0] lock_count;
  wire logic wr      = req && write;
  wire logic save_wr = wr && addr == radio_aux_pkg::power_saving_addr;
  wire logic carr_wr = wr && addr == radio_aux_pkg::carrier_override_addr;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      analog     <= 8'h00;
      control    <= 8'h00;
      lock_count <= radio_aux_pkg::lock_delay_reset;
    end else begin
      if (wr && addr == radio_aux_pkg::analog_ctrl_addr) analog <= wdata;
      if (wr && addr == radio_aux_pkg::control_addr) control <= wdata;
      if (wr && addr == radio_aux_pkg::lock_delay_addr) lock_count <= wdata;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_read_answer: assert property (req && !write |=> rvalid)
    else $error("read not answered next cycle");
  a_rvalid_cause: assert property (rvalid |-> $past(req && !write))
    else $error("read answer without a read");
  a_id_top_zero: assert property (rvalid && $past(addr) == 7'h3f |-> rdata[7:6] == 2'b00)
    else $error("identifier top bits not zero");
  a_id_gated: assert property (
    req && !write && addr[6:2] == 5'h0f && !analog[5] |=> rdata == 8'h00)
    else $error("identifier visible while read-enable clear");
  a_save_gated: assert property (save_wr && !analog[6] |=> $stable(power_save))
    else $error("power-saving bit changed without write-enable");
  a_save_write: assert property (save_wr && analog[6] |=> power_save == $past(wdata[7]))
    else $error("power-saving bit did not follow write");
  a_carrier_gated: assert property (
    carr_wr && !analog[6] |=> $stable(carrier_override))
    else $error("carrier bit changed without write-enable");
  a_carrier_write: assert property (
    carr_wr && analog[6] |=> carrier_override == $past(wdata[7]))
    else $error("carrier bit did not follow write");
  a_lock_start: assert property (
    synth_start && !control[1] && lock_count != 8'h00 |=> !synth_locked [*8])
    else $error("lock flag not cleared at timed start");
  a_lock_ignored: assert property (
    synth_start && control[1] && synth_locked |=> synth_locked)
    else $error("start not ignored under manual synth control");
  c_power_on: cover property ($rose(power_save));
  c_id_read: cover property (rvalid && analog[5]);
  c_lock_done: cover property ($rose(synth_locked));
endmodule : radio_aux_assertions

//--- tb/tb.sv
// Bench: an APB master commands the host controller, which drives the register bank.
// Assumes the two design ends face each other through radio_aux_if on one pclk.
`timescale 1ns/1ps
module tb;
  localparam logic [29:0] chip_id = 30'h1234567;  // Arbitrary value
  logic        pclk = 1'b0;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        synth_start;
  logic        synth_locked;
  logic        power_save;
  logic        carrier_override;
  logic [7:0]  clock_override;
  logic [7:0]  clock_enable;
  int          error_cnt = 0;
  int          checked = 0;
  radio_aux_if link ();
  radio_aux_host radio_aux_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .radio(link));
  radio_aux_regs #(.mfg_id(chip_id)) radio_aux_regs_i (.pclk(pclk), .presetn(presetn),
    .bus(link), .synth_start(synth_start), .synth_locked(synth_locked), .power_save(power_save),
    .carrier_override(carrier_override), .clock_override(clock_override),
    .clock_enable(clock_enable));
  radio_aux_assertions radio_aux_assertions_i (.pclk(pclk), .presetn(presetn), .req(link.req),
    .write(link.write), .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata),
    .rvalid(link.rvalid), .synth_start(synth_start), .synth_locked(synth_locked),
    .power_save(power_save), .carrier_override(carrier_override));
  always #2.5 pclk = ~pclk;
  // ----------------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      error_cnt++;
      $display("unexpected at %0t: seen %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Poll busy so no command is dropped as refused
  task automatic cmd(input logic [31:0] c);
    logic [31:0] r;
    logic        e;
    apb(1'b1, radio_aux_pkg::host_cmd_offset, c, r, e);
    do apb(1'b0, radio_aux_pkg::host_status_offset, 32'h0, r, e); while (r[0] !== 1'b0);
  endtask : cmd
  // Address and data share bit 7: write callers keep addr bit 0 equal to data bit 7
  task automatic acc(input logic w, input logic [6:0] a, input logic [7:0] d);
    cmd((32'h1 << radio_aux_pkg::cmd_go_bit) | {16'h0, w, 1'b0, a, 7'h0} | {24'h0, d});
  endtask : acc
  task automatic rd(input logic [6:0] a, output logic [31:0] v);
    logic [31:0] r;
    logic        e;
    acc(1'b0, a, 8'h00);
    apb(1'b0, radio_aux_pkg::host_rdata_offset, 32'h0, r, e);
    v = {24'h0, r[7:0]};
  endtask : rd
  task automatic pulse();
    @(posedge pclk);
    synth_start <= 1'b1;
    @(posedge pclk);
    synth_start <= 1'b0;
  endtask : pulse
  // ----------------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------------
  task automatic t_reset();
    logic [6:0]  a [5] = '{7'h2e, 7'h2f, 7'h32, 7'h33, 7'h38};
    logic [31:0] v;
    chk(power_save, 1'b0);
    for (int i = 0; i < 5; i++) begin
      rd(a[i], v);
      chk(v, (i == 4) ? 32'h64 : 32'h0);
    end
  endtask : t_reset
  task automatic t_gate();
    logic [31:0] v;
    acc(1'b1, radio_aux_pkg::carrier_override_addr, 8'h80);
    chk(carrier_override, 1'b0);
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, radio_aux_pkg::write_enable_value);
    acc(1'b1, radio_aux_pkg::carrier_override_addr, 8'h80);
    chk(carrier_override, 1'b1);
    rd(radio_aux_pkg::carrier_override_addr, v);
    chk(v, 32'h80);
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, 8'h00);
  endtask : t_gate
  task automatic t_init();
    logic [31:0] v;
    cmd(32'h1 << radio_aux_pkg::cmd_init_bit);
    chk(power_save, 1'b1);
    chk(clock_override, 8'h41);
    chk(clock_enable, 8'h41);
    rd(radio_aux_pkg::power_saving_addr, v);
    chk(v, 32'h80);
    acc(1'b1, radio_aux_pkg::power_saving_addr, 8'h00);
    chk(power_save, 1'b1);
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, radio_aux_pkg::write_enable_value);
    acc(1'b1, radio_aux_pkg::power_saving_addr, 8'h00);
    chk(power_save, 1'b0);
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, 8'h00);
  endtask : t_init
  task automatic t_id();
    logic [31:0] v;
    logic        e;
    rd(radio_aux_pkg::mfg_id_addr, v);
    chk(v, 32'h0);
    acc(1'b1, 7'h3d, 8'hff);
    cmd(32'h1 << radio_aux_pkg::cmd_id_bit);
    apb(1'b0, radio_aux_pkg::host_mfg_id_offset, 32'h0, v, e);
    chk(v, {2'b00, chip_id});
    rd(radio_aux_pkg::analog_ctrl_addr, v);
    chk(v, 32'h0);
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, radio_aux_pkg::id_read_enable_value);
    rd(7'h3c, v);
    chk(v, {24'h0, chip_id[7:0]});
    rd(7'h3f, v);
    chk(v, {26'h0, chip_id[29:24]});
    acc(1'b1, radio_aux_pkg::analog_ctrl_addr, 8'h00);
  endtask : t_id
  task automatic t_lock();
    int n = 0;
    acc(1'b1, radio_aux_pkg::lock_delay_addr, 8'h02);
    pulse();
    while (n < 2000) begin
      @(posedge pclk);
      #1;
      n++;
      if (synth_locked === 1'b1) break;
    end
    chk(n, 2 * radio_aux_pkg::lock_step_cycles);
    acc(1'b1, radio_aux_pkg::control_addr, 8'h82);
    pulse();
    repeat (5) @(posedge pclk);
    chk(synth_locked, 1'b1);
    acc(1'b1, radio_aux_pkg::control_addr, 8'h80);
  endtask : t_lock
  task automatic t_unmapped();
    logic [31:0] r;
    logic        e;
    apb(1'b0, 8'h10, 32'h0, r, e);
    chk(e, 1'b1);
    apb(1'b0, radio_aux_pkg::host_status_offset, 32'h0, r, e);
    chk(e, 1'b0);
  endtask : t_unmapped
  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_of_test
  initial begin
    presetn     = 1'b0;
    psel        = 1'b0;
    penable     = 1'b0;
    pwrite      = 1'b0;
    paddr       = 8'h00;
    pwdata      = 32'h0;
    synth_start = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_init();
    t_id();
    t_lock();
    t_unmapped();
    end_of_test();
  end
  // Generous bound: the timed lock wait dominates the run
  initial begin
    repeat (30000) @(posedge pclk);
    error_cnt++;
    end_of_test();
  end
endmodule : tb
